// ==== dv/async_serial_unit_tb_top.sv ====
// self-checking bench for the asynchronous serial unit
`timescale 1ns/1ps
`default_nettype none
`include "uart_defines.vh"
module async_serial_unit_tb_top;
  localparam int BT = 5;
  logic sys_clk_in, srst_in, wr_in, rd_in;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, d;
  wire [7:0] rdata_out;
  wire serial_in_pin_in, serial_out_pin_out;
  wire rx_complete_irq_out, tx_enable_irq_out;
  int miscompares = 0, samples_checked = 0, rx_cnt = 0, tx_cnt = 0, n, k, c;
  logic [15:0] got, exp;
  logic [7:0] cfg [4] = '{8'hE2, 8'hE7, 8'hF8, 8'hEE};
  async_serial_unit dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .serial_in_pin_in(serial_in_pin_in),
    .serial_out_pin_out(serial_out_pin_out),
    .rx_complete_irq_out(rx_complete_irq_out),
    .tx_enable_irq_out(tx_enable_irq_out));
  remote_node #(.BT(BT)) node (.clk_in(sys_clk_in),
    .rx_line_in(serial_out_pin_out), .tx_line_out(serial_in_pin_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    rx_cnt <= rx_cnt + int'(rx_complete_irq_out === 1'b1);
    tx_cnt <= tx_cnt + int'(tx_enable_irq_out === 1'b1);
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask
  // bounded wait for the next delivered character
  task automatic rxsend(input logic [15:0] b, input int nb);
    int s;
    s = rx_cnt;
    node.send(b, nb);
    for (int i = 0; i < 400 && rx_cnt <= s; i++) @(posedge sys_clk_in);
  endtask
  function automatic logic [15:0] fr(input logic [7:0] cr, input logic [7:0] v,
                                     output int nb);
    logic [15:0] f;
    int w;
    logic p;
    w = cr[`BIT_CL] ? 8 : 7;
    f = '0;
    nb = 1;
    p = 1'b0;
    for (int i = 0; i < w; i++) begin
      f[nb] = cr[`BIT_DIR] ? v[w-1-i] : v[i];
      p ^= f[nb];
      nb++;
    end
    if (cr[`BIT_PS1]) f[nb] = cr[`BIT_PS0] ? p : ~p;
    if (cr[`BIT_PS1] || cr[`BIT_PS0]) nb++;
    f[nb] = 1'b1;
    nb++;
    f[nb] = cr[`BIT_SL];
    nb += int'(cr[`BIT_SL]);
    return f;
  endfunction
  task automatic final_report;
    $display("miscompares=%0d samples_checked=%0d", miscompares,
             samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    final_report;
  end
  initial begin
    srst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    repeat (10) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    rdc(`ADDR_CTL0, `CTL0_RESET);
    rdc(`ADDR_OPT0, `OPT0_RESET);
    rdc(`ADDR_BAUD_LO, 8'h40);
    rdc(`ADDR_BAUD_HI, 8'h01);
    rdc(4'hF, 8'h00);
    wr(`ADDR_BITSET, 8'h07);
    rdc(`ADDR_CTL0, 8'h90);
    wr(`ADDR_BITCLR, 8'h04);
    rdc(`ADDR_CTL0, 8'h80);
    wr(`ADDR_BAUD_LO, 8'h04);
    wr(`ADDR_BAUD_HI, 8'h00);
    foreach (cfg[i]) begin
      wr(`ADDR_CTL0, cfg[i]);
      repeat (3) @(posedge sys_clk_in);
      d = 8'hA5 - 8'(i);
      exp = fr(cfg[i], d, n);
      fork
        node.capture(got, n);
        wr(`ADDR_TXD, d);
      join
      chk(got, exp);
      chk(16'(tx_cnt), 16'(i + 1));
      rxsend(exp, n);
      rdc(`ADDR_RXD, cfg[i][`BIT_CL] ? d : d & 8'h7F);
      rdc(`ADDR_STAT, 8'h00);
    end
    rxsend(exp ^ 16'h0200, n);
    rdc(`ADDR_STAT, 8'h01);
    exp = fr(8'hEE, 8'h3C, n);
    rxsend(exp, n);
    exp = fr(8'hEE, 8'hC3, n);
    rxsend(exp, n);
    rdc(`ADDR_STAT, 8'h04);
    rdc(`ADDR_RXD, 8'hC3);
    k = rx_cnt;
    node.tx_line_out <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    node.tx_line_out <= 1'b1;
    repeat (12 * BT) @(posedge sys_clk_in);
    chk(16'(rx_cnt), 16'(k));
    node.send(16'h0000, 11);
    repeat (4 * BT) @(posedge sys_clk_in);
    rdc(`ADDR_STAT, 8'h08);
    chk(16'(rx_cnt), 16'(k));
    rxsend(exp & ~16'h0400, n);
    rdc(`ADDR_STAT, 8'h02);
    // inverted input: line idles low, switched in the same step as the option
    exp = fr(8'hEE, 8'h5A, n);
    wr(`ADDR_OPT0, 8'h15);
    node.tx_line_out <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    node.send(~exp, n);
    node.tx_line_out <= 1'b0;
    repeat (4 * BT) @(posedge sys_clk_in);
    rdc(`ADDR_RXD, 8'h5A);
    wr(`ADDR_OPT0, 8'h14);
    node.tx_line_out <= 1'b1;
    fork
      node.lowlen(c);
      wr(`ADDR_OPT0, 8'hF4);
    join
    chk(16'(c), 16'(20 * BT));
    repeat (4 * BT) @(posedge sys_clk_in);
    wr(`ADDR_OPT0, 8'h16);
    repeat (3) @(posedge sys_clk_in);
    chk(serial_out_pin_out, 1'b0);
    wr(`ADDR_OPT0, 8'h14);
    k = tx_cnt;
    wr(`ADDR_CTL0, 8'h00);
    repeat (3) @(posedge sys_clk_in);
    wr(`ADDR_TXD, 8'h55);
    repeat (10 * BT) @(posedge sys_clk_in);
    chk(16'(tx_cnt), 16'(k));
    chk(serial_out_pin_out, 1'b1);
    final_report;
  end
endmodule // async_serial_unit_tb_top
`default_nettype wire

// ==== dv/remote_node.sv ====
// remote serial node: sends frames and watches the unit's line
`timescale 1ns/1ps
`default_nettype none
module remote_node #(
  parameter int BT = 5
) (
  input wire logic clk_in,
  input wire logic rx_line_in,
  output logic tx_line_out
);
  // idle high between frames, as a pulled-up line would sit
  initial tx_line_out = 1'b1;
  task automatic send(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      tx_line_out <= b[i];
      repeat (BT) @(posedge clk_in);
    end
    tx_line_out <= 1'b1;
  endtask
  // samples mid-bit; the start bit lands in bit 0
  task automatic capture(output logic [15:0] b, input int n);
    b = '0;
    @(negedge rx_line_in);
    repeat (BT / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      b[i] = rx_line_in;
      repeat (BT) @(posedge clk_in);
    end
  endtask
  task automatic lowlen(output int c);
    c = 0;
    @(negedge rx_line_in);
    do begin
      @(posedge clk_in);
      #1;
      c++;
    end while (rx_line_in === 1'b0);
  endtask
endmodule // remote_node
`default_nettype wire

// ==== dv/uart_checker_assertions.sv ====
// port-level assertions and covers for the serial unit
`timescale 1ns/1ps
`default_nettype none
`include "uart_defines.vh"
module uart_checker (
  input wire sys_clk_in,
  input wire srst_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire serial_in_pin_in,
  input wire serial_out_pin_out,
  input wire rx_complete_irq_out,
  input wire tx_enable_irq_out
);
  logic [7:0] ctl_q;
  logic inv_q;
  logic pend_q;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // software view of control zero, rebuilt from bus writes
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctl_q <= `CTL0_RESET;
      inv_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (wr_in && addr_in == `ADDR_CTL0) ctl_q <= wdata_in;
      if (wr_in && addr_in == `ADDR_BITSET) ctl_q[wdata_in[2:0]] <= 1'b1;
      if (wr_in && addr_in == `ADDR_BITCLR) ctl_q[wdata_in[2:0]] <= 1'b0;
      if (wr_in && addr_in == `ADDR_OPT0) inv_q <= wdata_in[`OPT_TDL];
      if (wr_in && addr_in == `ADDR_TXD) pend_q <= 1'b1;
      else if (tx_enable_irq_out) pend_q <= 1'b0;
    end
  end
  AST_RST_IDLE: assert property ($fell(srst_in) |-> serial_out_pin_out
    && rdata_out == 8'h00 && !tx_enable_irq_out && !rx_complete_irq_out)
    else $error("outputs not idle after reset");
  AST_RD_ZERO: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data without read");
  AST_CTL_READ: assert property (rd_in && addr_in == `ADDR_CTL0
    |=> rdata_out == $past(ctl_q)) else $error("control read differs");
  AST_RX_PULSE: assert property (rx_complete_irq_out
    |=> !rx_complete_irq_out) else $error("rx pulse too long");
  AST_TX_PULSE: assert property ($rose(tx_enable_irq_out)
    |=> !tx_enable_irq_out) else $error("tx pulse too long");
  AST_TX_CAUSE: assert property (tx_enable_irq_out |-> pend_q)
    else $error("tx pulse without data write");
  AST_RX_EN: assert property (rx_complete_irq_out
    |-> ctl_q[`BIT_PWR] && ctl_q[`BIT_RXE]) else $error("rx pulse disabled");
  AST_OFF_QUIET: assert property (!ctl_q[`BIT_PWR] [*3]
    |-> !rx_complete_irq_out && !tx_enable_irq_out)
    else $error("pulse while unpowered");
  AST_OFF_LINE: assert property ((!ctl_q[`BIT_PWR] && !inv_q) [*2]
    |-> serial_out_pin_out) else $error("line not idle while off");
  COV_RX: cover property (rx_complete_irq_out);
  COV_TX: cover property (tx_enable_irq_out);
  COV_RD: cover property (rd_in && addr_in == `ADDR_CTL0);
endmodule // uart_checker
bind async_serial_unit uart_checker u_chk (.sys_clk_in(sys_clk_in),
  .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .serial_in_pin_in(serial_in_pin_in),
  .serial_out_pin_out(serial_out_pin_out),
  .rx_complete_irq_out(rx_complete_irq_out),
  .tx_enable_irq_out(tx_enable_irq_out));
`default_nettype wire

// ==== hdl/async_serial_unit.v ====
// asynchronous serial channel with lin break support
`timescale 1ns/1ps
`default_nettype none
`include "uart_defines.vh"
//
// Behaviour
// - control register zero is 8 bits, resets to 10h.
// - control register takes byte writes and single-bit set/clear writes.
// - baud divisor covers 300 bps to 625 kbps.
// - tx and rx each have a data register and shift register.
// - rx complete pulse when shifter moves char into rx data register.
// - tx enable pulse when tx data moves into tx shifter.
// - sending needs power and tx enable; writing tx data starts it.
// - transmitter adds start, parity and stop bits itself.
// - frame is one start bit, data, optional parity, stop bits.
// - length, parity, stop count and bit order come from control zero.
// - seven or eight data bits per frame both ways.
// - parity odd, even, forced zero, or none.
// - one or two stop bits appended.
// - tx level option inverts the output line.
// - rx level option inverts the input line.
// - receive input passes a digital noise filter first.
// - parity, framing and overrun errors are flagged.
// - lin break sent with 13 to 20 bit times low.
// - low of 11 or more bit times sets break-received flag.
module async_serial_unit #(
  parameter DIV_W = 16
) (
  input wire sys_clk_in,
  input wire srst_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire serial_in_pin_in,
  output reg serial_out_pin_out,
  output reg rx_complete_irq_out,
  output reg tx_enable_irq_out
);
  reg [7:0] ctl_q;
  reg [7:0] opt_q;
  reg [DIV_W-1:0] baud_q;
  reg [7:0] txd_q;
  reg txd_full_q;
  reg [7:0] rxd_q;
  reg rxd_full_q;
  reg pe_q, fe_q, ove_q, sbf_q;
  reg [1:0] txe_dly_q, rxe_dly_q;
  wire pwr = ctl_q[`BIT_PWR];
  wire ch_rst = srst_in | ~pwr;
  wire tx_on = pwr & txe_dly_q[1];
  wire rx_on = pwr & rxe_dly_q[1];
  wire dir_msb = ctl_q[`BIT_DIR];
  wire [1:0] par_sel = {ctl_q[`BIT_PS1], ctl_q[`BIT_PS0]};
  wire len8 = ctl_q[`BIT_CL];
  wire stop2 = ctl_q[`BIT_SL];
  wire wr_ctl = wr_in & (addr_in == `ADDR_CTL0);
  wire wr_bset = wr_in & (addr_in == `ADDR_BITSET);
  wire wr_bclr = wr_in & (addr_in == `ADDR_BITCLR);
  wire rd_rxd = rd_in & (addr_in == `ADDR_RXD);
  wire rd_stat = rd_in & (addr_in == `ADDR_STAT);
  wire [7:0] bit_mask = 8'h01 << wdata_in[2:0];
  wire tx_load, rx_done, rx_pe, rx_fe, rx_brk;
  wire [7:0] rx_char;
  wire sbf_req = wr_in & (addr_in == `ADDR_OPT0) & wdata_in[`OPT_SBT];
  // register writes
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctl_q <= `CTL0_RESET;
      opt_q <= `OPT0_RESET;
      baud_q <= `BAUD_RESET;
    end else begin
      if (wr_ctl)
        ctl_q <= wdata_in;
      else if (wr_bset)
        ctl_q <= ctl_q | bit_mask;
      else if (wr_bclr)
        ctl_q <= ctl_q & ~bit_mask;
      if (wr_in & (addr_in == `ADDR_OPT0))
        opt_q <= {1'b0, wdata_in[6:0]};
      if (wr_in & (addr_in == `ADDR_BAUD_LO))
        baud_q[7:0] <= wdata_in;
      if (wr_in & (addr_in == `ADDR_BAUD_HI))
        baud_q[DIV_W-1:8] <= wdata_in[DIV_W-9:0];
    end
  end
  // enables settle two cycles after being set
  always @(posedge sys_clk_in) begin
    if (ch_rst) begin
      txe_dly_q <= 2'b00;
      rxe_dly_q <= 2'b00;
    end else begin
      txe_dly_q <= {txe_dly_q[0], ctl_q[`BIT_TXE]};
      rxe_dly_q <= {rxe_dly_q[0], ctl_q[`BIT_RXE]};
    end
  end
  // tx data register; software paces writes on the tx pulse
  always @(posedge sys_clk_in) begin
    if (ch_rst) begin
      txd_q <= 8'h00;
      txd_full_q <= 1'b0;
    end else begin
      if (wr_in & (addr_in == `ADDR_TXD) & tx_on) begin
        txd_q <= wdata_in;
        txd_full_q <= 1'b1;
      end else if (tx_load) begin
        txd_full_q <= 1'b0;
      end
    end
  end
  // rx data register and error flags; set wins over read clear
  always @(posedge sys_clk_in) begin
    if (ch_rst) begin
      rxd_q <= 8'h00;
      rxd_full_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      ove_q <= 1'b0;
      sbf_q <= 1'b0;
    end else begin
      if (rx_done) begin
        rxd_q <= rx_char;
        rxd_full_q <= 1'b1;
      end else if (rd_rxd) begin
        rxd_full_q <= 1'b0;
      end
      if (rx_done & rxd_full_q & ~rd_rxd)
        ove_q <= 1'b1;
      else if (rd_stat)
        ove_q <= 1'b0;
      if (rx_done & rx_pe)
        pe_q <= 1'b1;
      else if (rd_stat)
        pe_q <= 1'b0;
      if (rx_done & rx_fe)
        fe_q <= 1'b1;
      else if (rd_stat)
        fe_q <= 1'b0;
      if (rx_brk)
        sbf_q <= 1'b1;
      else if (rd_stat)
        sbf_q <= 1'b0;
    end
  end
  // ---------------- transmitter
  localparam TX_IDLE = 2'd0;
  localparam TX_SHIFT = 2'd1;
  localparam TX_BRK = 2'd2;
  reg [1:0] tx_st_q;
  reg [DIV_W-1:0] tx_cnt_q;
  reg [11:0] tx_sh_q;
  reg [4:0] tx_bits_q;
  reg tx_line_q;
  reg brk_pend_q;
  wire tx_tick = (tx_cnt_q == {DIV_W{1'b0}});
  wire [7:0] tx_ord = dir_msb ?
    (len8 ? {txd_q[0], txd_q[1], txd_q[2], txd_q[3],
             txd_q[4], txd_q[5], txd_q[6], txd_q[7]} :
            {1'b0, txd_q[0], txd_q[1], txd_q[2], txd_q[3],
             txd_q[4], txd_q[5], txd_q[6]}) :
    (len8 ? txd_q : {1'b0, txd_q[6:0]});
  wire tx_par_raw = len8 ? ^txd_q : ^txd_q[6:0];
  wire tx_par = (par_sel == 2'b01) ? 1'b0 :
                (par_sel == 2'b10) ? ~tx_par_raw : tx_par_raw;
  wire par_on = (par_sel != 2'b00);
  wire [3:0] nbits = (len8 ? 4'd8 : 4'd7) + {3'b000, par_on};
  assign tx_load = (tx_st_q == TX_IDLE) & txd_full_q & tx_on & ~brk_pend_q;
  always @(posedge sys_clk_in) begin
    if (ch_rst) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= {DIV_W{1'b0}};
      tx_sh_q <= 12'hFFF;
      tx_bits_q <= 5'd0;
      tx_line_q <= 1'b1;
      brk_pend_q <= 1'b0;
    end else begin
      if (sbf_req & tx_on)
        brk_pend_q <= 1'b1;
      tx_cnt_q <= tx_tick ? baud_q : tx_cnt_q - 1'b1;
      case (tx_st_q)
        TX_IDLE: begin
          tx_line_q <= 1'b1;
          if (tx_load) begin
            // start bit first, then data, parity, stop bits
            tx_sh_q <= len8 ?
              {2'b11, (par_on ? tx_par : 1'b1), tx_ord, 1'b0} :
              {3'b111, (par_on ? tx_par : 1'b1), tx_ord[6:0], 1'b0};
            tx_bits_q <= 5'd1 + {1'b0, nbits} + (stop2 ? 5'd2 : 5'd1);
            tx_cnt_q <= baud_q;
            tx_st_q <= TX_SHIFT;
          end else if (brk_pend_q & tx_on) begin
            brk_pend_q <= 1'b0;
            tx_bits_q <= 5'd`SBF_TX_BASE +
                         {2'b00, opt_q[`OPT_SBL_HI:`OPT_SBL_LO]};
            tx_cnt_q <= baud_q;
            tx_st_q <= TX_BRK;
          end
        end
        TX_SHIFT: begin
          tx_line_q <= tx_sh_q[0];
          if (tx_tick) begin
            tx_sh_q <= {1'b1, tx_sh_q[11:1]};
            tx_bits_q <= tx_bits_q - 1'b1;
            // parity off: skipped slot reads as stop (1)
            if (tx_bits_q == 5'd1)
              tx_st_q <= TX_IDLE;
          end
        end
        TX_BRK: begin
          tx_line_q <= 1'b0;
          if (tx_tick) begin
            tx_bits_q <= tx_bits_q - 1'b1;
            if (tx_bits_q == 5'd1)
              tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end
  // ---------------- receiver
  wire filt;
  noise_filter #(
    .LEN(`FILT_LEN)
  ) u_filt (
    .sys_clk_in(sys_clk_in),
    .srst_in(ch_rst),
    .raw_in(serial_in_pin_in ^ opt_q[`OPT_RDL]),
    .clean_out(filt)
  );
  localparam RX_IDLE = 2'd0;
  localparam RX_DATA = 2'd1;
  reg [1:0] rx_st_q;
  reg [DIV_W-1:0] rx_cnt_q;
  reg [3:0] rx_idx_q;
  reg [9:0] rx_sh_q;
  reg [4:0] low_bits_q;
  reg [DIV_W-1:0] low_cnt_q;
  reg brk_seen_q;
  reg done_q;
  wire rx_tick = (rx_cnt_q == {DIV_W{1'b0}});
  wire [3:0] rx_total = nbits + 4'd1;
  wire [7:0] rx_raw8 = len8 ? rx_sh_q[8:1] : {1'b0, rx_sh_q[7:1]};
  assign rx_char = dir_msb ?
    (len8 ? {rx_raw8[0], rx_raw8[1], rx_raw8[2], rx_raw8[3],
             rx_raw8[4], rx_raw8[5], rx_raw8[6], rx_raw8[7]} :
            {1'b0, rx_raw8[0], rx_raw8[1], rx_raw8[2], rx_raw8[3],
             rx_raw8[4], rx_raw8[5], rx_raw8[6]}) : rx_raw8;
  wire rx_par_bit = len8 ? rx_sh_q[9] : rx_sh_q[8];
  wire rx_par_calc = len8 ? ^rx_sh_q[8:1] : ^rx_sh_q[7:1];
  assign rx_pe = (par_sel == 2'b11) ? (rx_par_bit != rx_par_calc) :
                 (par_sel == 2'b10) ? (rx_par_bit == rx_par_calc) :
                 (par_sel == 2'b01) ? rx_par_bit : 1'b0;
  assign rx_fe = ~filt;
  assign rx_done = done_q;
  assign rx_brk = brk_seen_q;
  always @(posedge sys_clk_in) begin
    if (ch_rst) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= {DIV_W{1'b0}};
      rx_idx_q <= 4'd0;
      rx_sh_q <= 10'h000;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      rx_cnt_q <= rx_tick ? baud_q : rx_cnt_q - 1'b1;
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_on & ~filt) begin
            // first sample lands mid start bit
            rx_cnt_q <= {1'b0, baud_q[DIV_W-1:1]};
            rx_idx_q <= 4'd0;
            rx_st_q <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            if (rx_idx_q == rx_total) begin
              // stop-bit slot; a break shows here as low
              done_q <= ~(low_bits_q >= 5'd`SBF_RX_BITS - 5'd1);
              rx_st_q <= RX_IDLE;
            end else begin
              rx_sh_q[rx_idx_q] <= filt;
              rx_idx_q <= rx_idx_q + 1'b1;
              if (rx_idx_q == 4'd0 && filt)
                rx_st_q <= RX_IDLE;
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end
  // low-time meter for lin break detection
  always @(posedge sys_clk_in) begin
    if (ch_rst) begin
      low_bits_q <= 5'd0;
      low_cnt_q <= {DIV_W{1'b0}};
      brk_seen_q <= 1'b0;
    end else begin
      brk_seen_q <= 1'b0;
      if (filt | ~rx_on) begin
        brk_seen_q <= rx_on & (low_bits_q >= 5'd`SBF_RX_BITS);
        low_bits_q <= 5'd0;
        low_cnt_q <= baud_q;
      end else if (low_cnt_q == {DIV_W{1'b0}}) begin
        low_cnt_q <= baud_q;
        if (low_bits_q != 5'h1F)
          low_bits_q <= low_bits_q + 1'b1;
      end else begin
        low_cnt_q <= low_cnt_q - 1'b1;
      end
    end
  end
  // ---------------- outputs and read port
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      rdata_out <= 8'h00;
      serial_out_pin_out <= 1'b1;
      rx_complete_irq_out <= 1'b0;
      tx_enable_irq_out <= 1'b0;
    end else begin
      // unpowered line idles high, still honouring inversion
      serial_out_pin_out <= (pwr ? tx_line_q : 1'b1) ^ opt_q[`OPT_TDL];
      rx_complete_irq_out <= rx_done & rx_on;
      tx_enable_irq_out <= tx_load;
      rdata_out <= 8'h00;
      if (rd_in) begin
        case (addr_in)
          `ADDR_CTL0: rdata_out <= ctl_q;
          `ADDR_OPT0: rdata_out <= opt_q;
          `ADDR_TXD: rdata_out <= txd_q;
          `ADDR_RXD: rdata_out <= rxd_q;
          `ADDR_STAT: rdata_out <= {3'b000, (tx_st_q != TX_IDLE),
                                    sbf_q, ove_q, fe_q, pe_q};
          `ADDR_BAUD_LO: rdata_out <= baud_q[7:0];
          `ADDR_BAUD_HI: rdata_out <= baud_q[DIV_W-1:8];
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule // async_serial_unit
`default_nettype wire

// ==== hdl/noise_filter.v ====
// all-samples-equal digital noise filter for the serial input
`timescale 1ns/1ps
`default_nettype none
module noise_filter #(
  parameter LEN = 3
) (
  input wire sys_clk_in,
  input wire srst_in,
  input wire raw_in,
  output reg clean_out
);
  reg [LEN-1:0] hist_q;
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      hist_q <= {LEN{1'b1}};
      clean_out <= 1'b1;
    end else begin
      hist_q <= {hist_q[LEN-2:0], raw_in};
      // level changes only after LEN equal samples
      if (&hist_q)
        clean_out <= 1'b1;
      else if (~|hist_q)
        clean_out <= 1'b0;
    end
  end
endmodule // noise_filter
`default_nettype wire

// ==== hdl/uart_defines.vh ====
// register map, field positions, reset values and timing counts
`ifndef UART_DEFINES_VH
`define UART_DEFINES_VH
`define ADDR_CTL0 4'h0
`define ADDR_OPT0 4'h1
`define ADDR_TXD 4'h2
`define ADDR_RXD 4'h3
`define ADDR_STAT 4'h4
`define ADDR_BAUD_LO 4'h5
`define ADDR_BAUD_HI 4'h6
`define ADDR_BITSET 4'h7
`define ADDR_BITCLR 4'h8
`define CTL0_RESET 8'h10
`define OPT0_RESET 8'h14
`define BAUD_RESET 16'h0140
`define BIT_PWR 7
`define BIT_TXE 6
`define BIT_RXE 5
`define BIT_DIR 4
`define BIT_PS1 3
`define BIT_PS0 2
`define BIT_CL 1
`define BIT_SL 0
`define OPT_SBT 7
`define OPT_SBL_HI 6
`define OPT_SBL_LO 4
`define OPT_TDL 1
`define OPT_RDL 0
`define ST_PE 0
`define ST_FE 1
`define ST_OVE 2
`define ST_SBF 3
`define ST_TXBUSY 4
`define SBF_RX_BITS 11
`define SBF_TX_BASE 13
`define ENA_DELAY 2
`define FILT_LEN 3
`endif
